//--- rtl/rfh_pkg.sv
// Purpose: Shared constants for the receive FIFO host datapath
// Assumes: 32-bit AXI4-Lite register bus, one clock domain
// Notes:   Offsets are byte addresses of aligned 32-bit words
package rfh_pkg;

   // Register byte offsets
   localparam logic [7:0] REG_RXDATA = 8'h00;
   localparam logic [7:0] REG_RXSTAT = 8'h04;
   localparam logic [7:0] REG_FILL = 8'h08;
   localparam logic [7:0] REG_CFG = 8'h0c;
   localparam logic [7:0] REG_DPCTL = 8'h10;
   localparam logic [7:0] REG_CTRL = 8'h14;

   // Configuration register fields
   localparam int CFG_BURST_LSB = 0;
   localparam int CFG_PAD_BIT = 2;
   localparam int CFG_OFF_LSB = 8;
   localparam int CFG_FLUSH_BIT = 15;
   localparam logic [31:0] CFG_KEEP = 32'h0000_1f07;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;

   // Datapath control, control/status and fill fields
   localparam int DPC_SKIP_BIT = 31;
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_ERR_BIT = 1;
   localparam int FILL_STAT_LSB = 16;
   localparam logic EN_RST = 1'b0;

   // Status word layout
   localparam int ST_LEN_LSB = 16;
   localparam logic [12:0] ST_LOW_KEEP = 13'h1cfe;
   localparam logic [12:0] ST_ES_SRC = 13'h08c2;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {P_IDLE, P_LEAD, P_BODY, P_TAIL, P_PAD, P_STAT} rfh_pack_e;

endpackage : rfh_pkg

//--- rtl/rfh_fifo.sv
// Purpose: Flip-flop FIFO with flush, used for receive data and status
// Assumes: Push when full and pop when empty are ignored
// Notes:   DEPTH must be a power of two
`timescale 1ns/10ps
module rfh_fifo #(
   parameter int W = 33,
   parameter int DEPTH = 512
) (
   input logic clk,
   input logic rst,
   input logic flush,
   input logic push,
   input logic [W-1:0] din,
   input logic pop,
   output logic [W-1:0] head,
   output logic full,
   output logic empty,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("rfh_fifo: DEPTH must be a power of two");
   end

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   wire do_push = push && !full;
   wire do_pop = pop && !empty;

   // Flags straight from the occupancy counter
   assign full = cnt_r == (AW + 1)'(DEPTH);
   assign empty = cnt_r == '0;
   assign count = cnt_r;
   assign head = mem_r[rp_r];

   // Pointers; flush returns them to the reset state
   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (do_push) wp_r <= wp_r + AW'(1);
         if (do_pop) rp_r <= rp_r + AW'(1);
         cnt_r <= cnt_r + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
      end
   end

   // Storage needs no reset, pointers guard it
   always_ff @(posedge clk) begin
      if (do_push) mem_r[wp_r] <= din;
   end

endmodule : rfh_fifo

//--- rtl/rfh_pack.sv
// Purpose: Frames MAC words into the data FIFO with offset and padding
// Assumes: Status inputs are valid with the last data beat
// Notes:   Bit 32 of each pushed word marks the final word of a packet
`timescale 1ns/10ps
module rfh_pack
   import rfh_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic abort,
   input logic [4:0] cfg_off,
   input logic cfg_pad,
   input logic [1:0] cfg_burst,
   input logic in_valid,
   output logic in_ready,
   input logic [31:0] in_data,
   input logic in_last,
   input logic [31:0] in_status,
   output logic d_push,
   output logic [32:0] d_din,
   input logic d_full,
   output logic s_push,
   output logic [31:0] s_din,
   output logic idle
);
   rfh_pack_e st_r;
   logic [2:0] lead_r;
   logic [11:0] cnt_r;
   logic [31:0] carry_r;
   logic [1:0] sh_r;
   logic pad_r;
   logic [1:0] bsel_r;
   logic [31:0] stat_r;

   // Byte shift, burst arithmetic and tail decision
   wire [4:0] sh8 = {sh_r, 3'b000};
   wire [63:0] wide = {32'h0, in_data} << sh8;
   wire [11:0] cnt_inc = cnt_r + 12'h001;
   wire [11:0] bmask = (12'h004 << bsel_r) - 12'h001;
   wire pad_more = pad_r && ((cnt_inc & bmask) != 12'h000);
   wire [2:0] rem = (in_status[17:16] == 2'b00) ? 3'h4 : {1'b0, in_status[17:16]};
   wire tail_need = ({1'b0, sh_r} + rem) > 3'h4;
   wire beat = in_valid && in_ready;

   assign in_ready = (st_r == P_BODY) && !d_full;
   assign idle = st_r == P_IDLE;
   assign s_push = st_r == P_STAT;
   assign s_din = stat_r;

   // Word offered to the data FIFO in each state
   always_comb begin
      d_push = 1'b0;
      d_din = '0;
      case (st_r)
         P_LEAD: d_push = !d_full;
         P_BODY: begin
            d_push = beat;
            d_din = {in_last && !tail_need && !pad_more, wide[31:0] | carry_r};
         end
         P_TAIL: begin
            d_push = !d_full;
            d_din = {!pad_more, carry_r};
         end
         P_PAD: begin
            d_push = !d_full;
            d_din = {!pad_more, 32'h0};
         end
         default: d_push = 1'b0;
      endcase
   end

   // Packet sequencer; settings are caught per packet
   always_ff @(posedge clk) begin
      if (rst || abort) begin
         st_r <= P_IDLE;
         lead_r <= '0;
         cnt_r <= '0;
         carry_r <= '0;
         sh_r <= '0;
         pad_r <= 1'b0;
         bsel_r <= '0;
         stat_r <= '0;
      end else begin
         if (d_push) cnt_r <= cnt_inc;
         case (st_r)
            P_IDLE: if (in_valid) begin
               sh_r <= cfg_off[1:0];
               lead_r <= cfg_off[4:2];
               pad_r <= cfg_pad;
               bsel_r <= cfg_burst;
               cnt_r <= '0;
               carry_r <= '0;
               st_r <= (cfg_off[4:2] != 3'h0) ? P_LEAD : P_BODY;
            end
            P_LEAD: if (d_push) begin
               lead_r <= lead_r - 3'h1;
               if (lead_r == 3'h1) st_r <= P_BODY;
            end
            P_BODY: if (beat) begin
               carry_r <= wide[63:32];
               if (in_last) begin
                  stat_r <= in_status;
                  st_r <= tail_need ? P_TAIL : (pad_more ? P_PAD : P_STAT);
               end
            end
            P_TAIL, P_PAD: if (d_push) st_r <= pad_more ? P_PAD : P_STAT;
            P_STAT: st_r <= P_IDLE;
            default: st_r <= P_IDLE;
         endcase
      end
   end

endmodule : rfh_pack

//--- rtl/rfh_top.sv
// Purpose: Receive FIFO datapath with AXI4-Lite host access
// Assumes: MAC side runs on SYS_CLK; RST is synchronous, active high
// Notes:   Data and status FIFOs drain through read-to-pop ports
// What this block does
// - Store each incoming frame word in the data FIFO, advancing its write pointer.
// - Queue one status word per frame in its own FIFO after the data.
// - Report queued data words and status words in the fill register.
// - Allow status words to be read before any of their data.
// - Underrun of either FIFO raises the error flag; host then clears it by writing one to the error bit.
// - Shift each packet start by a 0 to 31 byte offset.
// - With padding on, pad each packet to a whole host burst.
// - Keep packet boundaries; offset and padding apply per packet.
// - Skip bit drops the head data packet, then clears itself.
// - Skip touches the data FIFO only, never the status FIFO.
// - Flush bit resets pointers of both receive FIFOs.
// - Flush bit clears itself once both FIFOs are flushed.
// - Status bit 31 zero, bit 30 filter fail, bits 29:16 length.
// - Status bit 15 is the OR of bits 11, 7, 6 and 1.
// - Status bit 13 marks broadcast; bit 14 reads zero.
// - Pulse the halted event when the disabled receiver goes idle.
// - Status FIFO overrun raises the error flag; reception continues.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
module rfh_top
   import rfh_pkg::*;
#(
   parameter int DATA_DEPTH = 512,
   parameter int STAT_DEPTH = 32
) (
   input logic SYS_CLK,
   input logic RST,
   input logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input logic [7:0] S_AXI_AWADDR,
   input logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input logic [31:0] S_AXI_WDATA,
   input logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_BVALID,
   input logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   input logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input logic [7:0] S_AXI_ARADDR,
   output logic S_AXI_RVALID,
   input logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   input logic MAC_VALID,
   output logic MAC_READY,
   input logic [31:0] MAC_DATA,
   input logic MAC_LAST,
   input logic [13:0] MAC_LEN,
   input logic MAC_FILT_FAIL,
   input logic MAC_BCAST,
   input logic [12:0] MAC_STAT_LOW,
   output logic MAC_RX_ENABLE,
   output logic RX_HALTED_EVENT,
   output logic RX_ERROR
);
   localparam int DCW = $clog2(DATA_DEPTH) + 1;
   localparam int SCW = $clog2(STAT_DEPTH) + 1;

   if (DATA_DEPTH > 32768 || STAT_DEPTH > 128) begin : g_bad_depth
      $error("rfh_top: depth too large for the fill register");
   end

   // Bus holding registers
   logic aw_held_r;
   logic [7:0] aw_addr_r;
   logic w_held_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   // Software visible state
   logic [31:0] cfg_r;
   logic flush_r;
   logic skip_r;
   logic en_r;
   logic err_r;
   logic halted_r;
   logic evt_r;

   // FIFO and packer wiring
   logic d_push;
   logic [32:0] d_din;
   logic [32:0] d_head;
   logic d_full;
   logic d_empty;
   logic [DCW-1:0] d_count;
   logic s_push;
   logic [31:0] s_din;
   logic [31:0] s_head;
   logic s_full;
   logic s_empty;
   logic [SCW-1:0] s_count;
   logic pk_idle;

   // Write side decode
   wire do_write = aw_held_r && w_held_r && !bvalid_r;
   wire [7:0] wa = {aw_addr_r[7:2], 2'b00};
   wire w_cfg = do_write && wa == REG_CFG;
   wire w_dpc = do_write && wa == REG_DPCTL;
   wire w_ctl = do_write && wa == REG_CTRL;
   wire w_ro = wa == REG_RXDATA || wa == REG_RXSTAT || wa == REG_FILL;
   wire w_map = w_ro || wa == REG_CFG || wa == REG_DPCTL || wa == REG_CTRL;
   wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                        {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   wire [31:0] wbits = w_data_r & wmask;
   wire [31:0] cfg_nxt = ((cfg_r & ~wmask) | wbits) & CFG_KEEP;
   wire flush_set = w_cfg && wbits[CFG_FLUSH_BIT];
   wire skip_set = w_dpc && wbits[DPC_SKIP_BIT];
   wire en_nxt = (w_ctl && w_strb_r[0]) ? w_data_r[CTL_EN_BIT] : en_r;
   wire err_clr = w_ctl && wbits[CTL_ERR_BIT];

   // Read side decode; ports pop on the address handshake
   wire do_read = S_AXI_ARVALID && !rvalid_r;
   wire [7:0] ra = {S_AXI_ARADDR[7:2], 2'b00};
   wire r_data = do_read && ra == REG_RXDATA;
   wire r_stat = do_read && ra == REG_RXSTAT;
   wire r_map = ra == REG_RXDATA || ra == REG_RXSTAT || ra == REG_FILL ||
                ra == REG_CFG || ra == REG_DPCTL || ra == REG_CTRL;
   wire d_under = r_data && d_empty && !skip_r;
   wire s_under = r_stat && s_empty;
   wire s_ovr = s_push && s_full;
   wire err_set = d_under || s_under || s_ovr;

   // Data FIFO pop: a pending skip owns the read pointer
   wire skip_pop = skip_r && !d_empty;
   wire d_pop = skip_pop || (r_data && !skip_r);
   wire skip_done = skip_pop && d_head[32];
   wire s_pop = r_stat;
   wire halted = !en_r && pk_idle;

   // Register read mux
   wire [31:0] fill_word = {8'h00, 8'(s_count), 16'(d_count)};
   wire [31:0] cfg_word = cfg_r | ({31'h0, flush_r} << CFG_FLUSH_BIT);
   wire [31:0] dpc_word = {skip_r, 31'h0};
   wire [31:0] ctl_word = {29'h0, halted_r, err_r, en_r};
   wire [31:0] rd_word =
      (ra == REG_RXDATA) ? (d_empty ? 32'h0 : d_head[31:0]) :
      (ra == REG_RXSTAT) ? (s_empty ? 32'h0 : s_head) :
      (ra == REG_FILL) ? fill_word :
      (ra == REG_CFG) ? cfg_word :
      (ra == REG_DPCTL) ? dpc_word :
      (ra == REG_CTRL) ? ctl_word : 32'h0;

   // Status word assembled from MAC flags
   wire [12:0] st_low = MAC_STAT_LOW & ST_LOW_KEEP;
   wire st_es = |(st_low & ST_ES_SRC);
   wire [31:0] st_word = {1'b0, MAC_FILT_FAIL, MAC_LEN, st_es,
                          1'b0, MAC_BCAST, st_low};

   assign S_AXI_AWREADY = !aw_held_r;
   assign S_AXI_WREADY = !w_held_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_ARREADY = !rvalid_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   assign MAC_RX_ENABLE = en_r;
   assign RX_HALTED_EVENT = evt_r;
   assign RX_ERROR = err_r;

   // Address and data are caught independently
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_held_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else begin
         if (S_AXI_AWVALID && !aw_held_r) aw_addr_r <= S_AXI_AWADDR;
         if (S_AXI_WVALID && !w_held_r) w_data_r <= S_AXI_WDATA;
         if (S_AXI_WVALID && !w_held_r) w_strb_r <= S_AXI_WSTRB;
         aw_held_r <= do_write ? 1'b0 : (aw_held_r || S_AXI_AWVALID);
         w_held_r <= do_write ? 1'b0 : (w_held_r || S_AXI_WVALID);
      end
   end

   // Write and read responses
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else begin
         if (do_write) bresp_r <= w_map ? RESP_OKAY : RESP_SLVERR;
         bvalid_r <= do_write || (bvalid_r && !S_AXI_BREADY);
         if (do_read) rdata_r <= rd_word;
         if (do_read) rresp_r <= r_map ? RESP_OKAY : RESP_SLVERR;
         rvalid_r <= do_read || (rvalid_r && !S_AXI_RREADY);
      end
   end

   // Configuration and self-clearing command bits; a set beats the clear
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg_r <= CFG_RST;
         flush_r <= 1'b0;
         skip_r <= 1'b0;
         en_r <= EN_RST;
      end else begin
         if (w_cfg) cfg_r <= cfg_nxt;
         flush_r <= flush_set;
         skip_r <= skip_set || (skip_r && !skip_done);
         en_r <= en_nxt;
      end
   end

   // Error flag and halted event
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         err_r <= 1'b0;
         halted_r <= 1'b1; // Idle level, so reset release gives no false event
         evt_r <= 1'b0;
      end else begin
         err_r <= err_set || (err_r && !err_clr);
         halted_r <= halted;
         evt_r <= halted && !halted_r;
      end
   end

   // Frame packer; a flush also abandons a partly written frame
   rfh_pack u_pack (
      .clk(SYS_CLK),
      .rst(RST),
      .abort(flush_r),
      .cfg_off(cfg_r[CFG_OFF_LSB +: 5]),
      .cfg_pad(cfg_r[CFG_PAD_BIT]),
      .cfg_burst(cfg_r[CFG_BURST_LSB +: 2]),
      .in_valid(MAC_VALID),
      .in_ready(MAC_READY),
      .in_data(MAC_DATA),
      .in_last(MAC_LAST),
      .in_status(st_word),
      .d_push(d_push),
      .d_din(d_din),
      .d_full(d_full),
      .s_push(s_push),
      .s_din(s_din),
      .idle(pk_idle)
   );

   // Receive data FIFO, tagged with end of packet
   rfh_fifo #(.W(33), .DEPTH(DATA_DEPTH)) u_dfifo (
      .clk(SYS_CLK),
      .rst(RST),
      .flush(flush_r),
      .push(d_push),
      .din(d_din),
      .pop(d_pop),
      .head(d_head),
      .full(d_full),
      .empty(d_empty),
      .count(d_count)
   );

   // Receive status FIFO; an overrun word is dropped
   rfh_fifo #(.W(32), .DEPTH(STAT_DEPTH)) u_sfifo (
      .clk(SYS_CLK),
      .rst(RST),
      .flush(flush_r),
      .push(s_push),
      .din(s_din),
      .pop(s_pop),
      .head(s_head),
      .full(s_full),
      .empty(s_empty),
      .count(s_count)
   );

   // Checks on the datapath
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   a_data_push_count: assert property (
      MAC_VALID && MAC_READY && !d_pop && !flush_r |=> d_count == $past(d_count) + DCW'(1))
      else $error("data word not stored");
   a_stat_after_data: assert property (
      s_push |-> $past(d_push && d_din[32]))
      else $error("status not after final data word");
   a_fill_report: assert property (
      do_read && ra == REG_FILL |=> S_AXI_RDATA[15:0] == 16'($past(d_count)))
      else $error("fill register wrong");
   a_underrun_err: assert property (
      d_under || s_under |=> err_r && RX_ERROR)
      else $error("underrun not flagged");
   a_status_pop: assert property (
      r_stat && !s_empty |=> S_AXI_RDATA == $past(s_head) && S_AXI_RVALID)
      else $error("status read not oldest word");
   a_skip_clears: assert property (
      skip_done && !skip_set |=> !skip_r)
      else $error("skip bit not cleared");
   a_skip_keeps_stat: assert property (
      skip_r && !s_push && !s_pop && !flush_r |=> $stable(s_count))
      else $error("skip moved status fifo");
   a_flush_empties: assert property (
      flush_r |=> d_count == '0 && s_count == '0)
      else $error("flush left entries");
   a_flush_self_clr: assert property (
      flush_r && !flush_set |=> !flush_r)
      else $error("flush bit stuck");
   a_stat_format: assert property (
      s_push |-> !s_din[31] && !s_din[14])
      else $error("status reserved bits set");
   a_es_summary: assert property (
      s_push |-> s_din[15] == (s_din[11] | s_din[7] | s_din[6] | s_din[1]))
      else $error("error summary wrong");
   a_halt_event: assert property (
      $rose(halted_r) |-> RX_HALTED_EVENT ##1 !RX_HALTED_EVENT)
      else $error("halted event not one pulse");
   a_overrun_err: assert property (
      s_ovr |=> err_r)
      else $error("status overrun not flagged");

   c_skip_done: cover property (skip_done);
   c_flush: cover property (flush_r && !d_empty);
   c_status_read: cover property (r_stat && !s_empty ##[1:20] r_data && !d_empty);
   c_padded: cover property (d_push && d_din[32] && d_din[31:0] == 32'h0);

endmodule : rfh_top

//--- dv/rfh_host.sv
// Purpose: CPU-side AXI4-Lite master model
// Assumes: One write and one read outstanding at most
// Notes:   Ready sampled mid-cycle, acted on at the next rising edge
`timescale 1ns/10ps
module rfh_host (
   input logic clk,
   output logic awvalid,
   input logic awready,
   output logic [7:0] awaddr,
   output logic wvalid,
   input logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input logic bvalid,
   output logic bready,
   output logic arvalid,
   input logic arready,
   output logic [7:0] araddr,
   input logic rvalid,
   output logic rready,
   input logic [31:0] rdata,
   output logic tmo
);
   // Idle bus at time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, tmo} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
   end
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      int k;
      logic ha, hw, hb;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      for (k = 0; k < 200; k++) begin
         @(negedge clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) break;
      end
      bready <= 1'b0;
      if (k == 200) tmo <= 1'b1;
   endtask : wr
   // Read data sampled mid-cycle while RVALID is high; no fixed latency assumed
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int k;
      logic ha, hr;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      for (k = 0; k < 200; k++) begin
         @(negedge clk);
         ha = arvalid && arready;
         hr = rvalid;
         d = rdata;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
         if (hr) break;
      end
      rready <= 1'b0;
      if (k == 200) tmo <= 1'b1;
   endtask : rd
endmodule : rfh_host

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the receive FIFO host datapath
// Assumes: Read answers return in issue order
// Notes:   Status FIFO kept small so an overrun is cheap to reach
`timescale 1ns/10ps
module tb_top
   import rfh_pkg::*;
;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] rs;} rfh_exp_s;
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, tmo;
   logic arvalid, arready, rvalid, rready, mvalid, mready, mlast, mff, mbc;
   logic rx_en, halt_ev, rx_err;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, mdata, got;
   logic [1:0] bresp, rresp;
   logic [3:0] wstrb;
   logic [13:0] mlen;
   logic [12:0] mlo;
   rfh_exp_s expq[$];
   rfh_exp_s e;
   logic [31:0] fw[$], fa[$], sq[$];
   int seed = 32'h9609;
   int n_fail = 0, n_compared = 0, n_halt = 0, s, offs, h0, k;

   rfh_top #(.DATA_DEPTH(128), .STAT_DEPTH(4)) u_rfh_top (
      .SYS_CLK(clk), .RST(rst), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .MAC_VALID(mvalid), .MAC_READY(mready), .MAC_DATA(mdata), .MAC_LAST(mlast),
      .MAC_LEN(mlen), .MAC_FILT_FAIL(mff), .MAC_BCAST(mbc), .MAC_STAT_LOW(mlo),
      .MAC_RX_ENABLE(rx_en), .RX_HALTED_EVENT(halt_ev), .RX_ERROR(rx_err));
   rfh_host u_rfh_host (
      .clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .tmo(tmo));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic finish_test();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   task automatic hang();
      n_fail++;
      finish_test();
   endtask : hang
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      n_compared++;
      if (y !== x) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, x, y);
      end
   endtask : chk
   // Note the expected answer, then issue the read
   task automatic rdx(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] rs);
      expq.push_back('{d & m, m, rs});
      u_rfh_host.rd(a, got);
   endtask : rdx
   // Oldest note against each read answer as it appears
   always @(negedge clk) begin
      if (rvalid && rready) begin
         e = expq.pop_front();
         chk("rdata", e.d, rdata & e.m);
         chk("rresp", {30'h0, e.rs}, {30'h0, rresp});
      end
      if (bvalid && bready) begin
         chk("bresp", {30'h0, (awaddr > REG_CTRL) ? RESP_SLVERR : RESP_OKAY}, {30'h0, bresp});
      end
   end
   always @(posedge clk) if (halt_ev === 1'b1) n_halt <= n_halt + 1;
   always @(posedge tmo) hang();
   // One frame of random words; random status bits ride with the last word
   task automatic send(input int nw);
      int i, j;
      logic ok, f, c;
      logic [12:0] l;
      l = 13'($random(seed));
      f = 1'($random(seed));
      c = 1'($random(seed));
      fw.delete();
      {mlo, mff, mbc, mlen} <= {l, f, c, 14'(4 * nw)};
      sq.push_back({1'b0, f, 14'(4 * nw), |(l & ST_ES_SRC), 1'b0, c, l & ST_LOW_KEEP});
      for (i = 0; i < nw; i++) begin
         fw.push_back($random(seed));
         mvalid <= 1'b1;
         mdata <= fw[i];
         mlast <= (i == nw - 1);
         ok = 1'b0;
         for (j = 0; j < 200 && !ok; j++) begin
            @(negedge clk);
            ok = (mready === 1'b1);
            @(posedge clk);
         end
         if (!ok) hang();
      end
      mvalid <= 1'b0;
      mlast <= 1'b0;
      repeat (40) @(posedge clk);
   endtask : send
   // Lead offset bytes, payload, zero tail; padding words are read but not compared
   task automatic get_pkt(input logic [31:0] q[$], input int of, input int bw);
      logic [7:0] b[$];
      int i, nw;
      for (i = 0; i < of; i++) b.push_back(8'h00);
      foreach (q[j]) for (i = 0; i < 4; i++) b.push_back(q[j][8*i +: 8]);
      while (b.size() % 4) b.push_back(8'h00);
      nw = b.size() / 4;
      if (bw > 0) nw = (nw + bw - 1) / bw * bw;
      for (i = 0; i < nw; i++)
         if (i < b.size() / 4) rdx(REG_RXDATA, {b[4*i+3], b[4*i+2], b[4*i+1], b[4*i]},
                                   '1, RESP_OKAY);
         else rdx(REG_RXDATA, 32'h0, 32'h0, RESP_OKAY);
   endtask : get_pkt

   initial begin
      rst = 1'b1;
      {mvalid, mlast, mff, mbc, mdata, mlen, mlo} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rdx(REG_CTRL, 32'h4, 32'h7, RESP_OKAY);
      rdx(8'h40, 32'h0, '1, RESP_SLVERR);
      u_rfh_host.wr(8'h40, 32'h0);
      u_rfh_host.wr(REG_CTRL, 32'h1);
      chk("rx_enable", 32'h1, {31'h0, rx_en});
      // Every burst size, two packets each, statuses read ahead of data
      for (s = 0; s < 4; s++) begin
         offs = (s == 3) ? 31 : ($random(seed) & 31);
         u_rfh_host.wr(REG_CFG, 32'((offs << CFG_OFF_LSB) | 4 | s));
         send(s + 2);
         fa = fw;
         send(1);
         rdx(REG_FILL, 32'h0002_0000, 32'hffff_0000, RESP_OKAY);
         rdx(REG_RXSTAT, sq.pop_front(), '1, RESP_OKAY);
         rdx(REG_RXSTAT, sq.pop_front(), '1, RESP_OKAY);
         get_pkt(fa, offs, 4 << s);
         get_pkt(fw, offs, 4 << s);
      end
      // Skip the head packet; the status queue stays whole
      u_rfh_host.wr(REG_CFG, 32'h0);
      send(4);
      send(2);
      rdx(REG_FILL, 32'h0002_0006, '1, RESP_OKAY);
      u_rfh_host.wr(REG_DPCTL, 32'h8000_0000);
      got = '1;
      for (k = 0; k < 50 && got[31] !== 1'b0; k++) rdx(REG_DPCTL, 0, 0, RESP_OKAY);
      chk("skip_bit", 32'h0, {31'h0, got[31]});
      rdx(REG_FILL, 32'h0002_0002, '1, RESP_OKAY);
      rdx(REG_RXSTAT, sq.pop_front(), '1, RESP_OKAY);
      rdx(REG_RXSTAT, sq.pop_front(), '1, RESP_OKAY);
      get_pkt(fw, 0, 0);
      // Underrun of each port raises the error flag; write-one clears it
      for (s = 0; s < 2; s++) begin
         rdx(s ? REG_RXSTAT : REG_RXDATA, 32'h0, '1, RESP_OKAY);
         repeat (2) @(posedge clk);
         chk("rx_error", 32'h1, {31'h0, rx_err});
         u_rfh_host.wr(REG_CTRL, 32'h3);
         repeat (2) @(posedge clk);
         chk("rx_error", 32'h0, {31'h0, rx_err});
      end
      // Five frames into four status slots; data still lands
      for (s = 0; s < 5; s++) send(1);
      rdx(REG_FILL, 32'h0004_0005, '1, RESP_OKAY);
      chk("rx_error", 32'h1, {31'h0, rx_err});
      // Halt, confirm, then flush both queues; no event may precede the halt
      h0 = n_halt;
      chk("halt_events", 32'h0, 32'(h0));
      u_rfh_host.wr(REG_CTRL, 32'h2);
      repeat (4) @(posedge clk);
      chk("halt_events", 32'h1, 32'(n_halt - h0));
      rdx(REG_CTRL, 32'h4, 32'h7, RESP_OKAY);
      u_rfh_host.wr(REG_CFG, 32'h8000);
      rdx(REG_CFG, 32'h0, 32'h8000, RESP_OKAY);
      rdx(REG_FILL, 32'h0, '1, RESP_OKAY);
      // Byte lanes: only lane 0 lands, masked to the kept bits
      u_rfh_host.wr(REG_CFG, 32'hffff_ffff, 4'h1);
      rdx(REG_CFG, CFG_KEEP & 32'h0000_00ff, '1, RESP_OKAY);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule : tb_top
